//--- core/isp_defines.svh
// constants for the isa slave bus port: widths, reset values, strap and mapping defaults
`ifndef ISP_DEFINES_SVH
`define ISP_DEFINES_SVH

`define ISP_SA_W        12
`define ISP_SA_HI_W     4
`define ISP_DATA_W      8
`define ISP_NCHAN       3
`define ISP_NIRQ        6
`define ISP_CHMAP_W     3
`define ISP_IRQMAP_W    4
`define ISP_FIFO_DEPTH  16
// bus channels 0, 1, 3 for the first, second and third request
`define ISP_DMA_MAP_RST 9'h0c8
// bus lines 5, 7, 9, 11, 12, 15 for the first to sixth interrupt output
`define ISP_IRQ_MAP_RST 24'hfc_b975
// strap level that selects upper address inputs
`define ISP_STRAP_ADDR  1'b1
`define ISP_HI_ZERO     4'h0

`endif

//--- core/isp_pkg.sv
// types shared by the isa slave bus port modules
package isp_pkg;
    typedef enum logic [1:0] {
        ISP_IDLE = 2'b00,
        ISP_WAIT = 2'b01,
        ISP_HOLD = 2'b10
    } isp_state_t;

    typedef enum logic [2:0] {
        ISP_K_NONE = 3'b000,
        ISP_K_IORD = 3'b001,
        ISP_K_IOWR = 3'b010,
        ISP_K_DMWR = 3'b011,
        ISP_K_DMRD = 3'b100
    } isp_kind_t;
endpackage : isp_pkg

//--- core/isp_fifo_if.sv
// valid/ready stream carrier between the bus port and its fifo
`timescale 1ns/1ns
interface isp_fifo_if #(
    parameter int WIDTH = 8
);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;

    modport fifo (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
    modport ctl  (output in_valid, output in_data, input in_ready,
                  input out_valid, input out_data, output out_ready);
endinterface : isp_fifo_if

//--- core/isp_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module isp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    isp_fifo_if.fifo  fi
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("isp_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;

    wire push = fi.in_valid & fi.in_ready;
    wire pop  = fi.out_valid & fi.out_ready;

    assign fi.in_ready  = (count_q != (AW+1)'(DEPTH));
    assign fi.out_valid = (count_q != '0);
    assign fi.out_data  = mem[rd_ptr_q];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_q] <= fi.in_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + AW'(push);
            rd_ptr_q <= rd_ptr_q + AW'(pop);
            count_q  <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_no_overrun : assert property (@(posedge mclk) disable iff (!rst_n)
        count_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : isp_fifo

//--- core/isp_bus_port.sv
// isa slave bus port: io decode, strobes, channel ready, dma pairs, interrupt outputs
`timescale 1ns/1ns
`include "isp_defines.svh"

// What this block does
// - decode low address lines against configured windows, select matching function
// - in upper-address mode accept io decode only when upper four bits are zero
// - read strobe strap level at reset release picks upper-address or drive mode
// - address enable low means io cycle, high means dma cycle
// - low read strobe reads a decoded register or dma byte onto data bus
// - low write strobe stores data byte to decoded register or dma path
// - hold channel ready low until the access can complete; host stretches
// - dma request stays high until all bytes of current transfer type moved
// - dma requests default to bus channels 0, 1, 3; resource data remaps
// - on acknowledge capture data byte on first-channel dma write, drive byte on second- or third-channel dma read
// - each interrupt output driven only when individually enabled by configuration
// - interrupt outputs default to lines 5,7,9,11,12,15; resource data remaps
module isp_bus_port #(
    parameter int NWIN  = 4,
    parameter int DEPTH = `ISP_FIFO_DEPTH
) (
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    input  wire logic [`ISP_SA_W-1:0]        sa,
    input  wire logic [`ISP_SA_HI_W-1:0]     ext_addr_hi,
    input  wire logic                        aen,
    input  wire logic                        ior_n,
    input  wire logic                        iow_n,
    input  wire logic [7:0]                  sd_in,
    output logic      [7:0]                  sd_out,
    output logic                             sd_oe,
    output logic                             iochrdy_out,
    output logic                             iochrdy_oe,
    input  wire logic                        dma_ack_first_n,
    input  wire logic                        dma_ack_second_n,
    input  wire logic                        dma_ack_third_n,
    output logic                             dma_req_first,
    output logic                             dma_req_second,
    output logic                             dma_req_third,
    output logic      [`ISP_NIRQ-1:0]        host_irq_out,
    output logic      [`ISP_NIRQ-1:0]        host_irq_oe,
    input  wire logic                        peripheral_read_strobe_in,
    output logic                             addr_hi_mode,
    input  wire logic [NWIN-1:0]             cfg_win_en,
    input  wire logic [NWIN*`ISP_SA_W-1:0]   cfg_win_base,
    input  wire logic [NWIN*`ISP_SA_W-1:0]   cfg_win_mask,
    input  wire logic [`ISP_NCHAN-1:0]       cfg_chan_en,
    input  wire logic [1:0]                  cfg_xfer_bytes,
    input  wire logic [`ISP_NIRQ-1:0]        cfg_irq_en,
    input  wire logic                        res_load,
    input  wire logic [8:0]                  res_dma_map,
    input  wire logic [23:0]                 res_irq_map,
    output logic      [8:0]                  dma_chan_map,
    output logic      [23:0]                 irq_line_map,
    output logic      [NWIN-1:0]             reg_sel,
    output logic      [`ISP_SA_W-1:0]        reg_addr,
    output logic                             reg_wr,
    output logic                             reg_rd,
    output logic      [7:0]                  reg_wdata,
    input  wire logic [7:0]                  reg_rdata,
    input  wire logic                        reg_rvalid,
    output logic      [7:0]                  play_data,
    output logic                             play_valid,
    input  wire logic                        play_ready,
    input  wire logic [15:0]                 cap_data,
    input  wire logic [1:0]                  cap_valid,
    output logic      [1:0]                  cap_ready,
    input  wire logic [`ISP_NIRQ-1:0]        irq_evt
);
    generate
        if (NWIN < 1 || NWIN > 8) begin : g_bad
            $error("isp_bus_port: NWIN must be 1..8");
        end
    endgenerate

    function automatic logic win_match(input logic [11:0] a, input logic [11:0] base,
                                       input logic [11:0] mask);
        win_match = ((a ^ base) & ~mask) == 12'h000;
    endfunction : win_match

    function automatic logic [NWIN-1:0] first_one(input logic [NWIN-1:0] v);
        first_one = v & (~v + NWIN'(1));
    endfunction : first_one

    isp_pkg::isp_state_t st_q;
    isp_pkg::isp_state_t st_d;
    isp_pkg::isp_kind_t  kind_q;
    isp_pkg::isp_kind_t  new_kind;
    isp_pkg::isp_kind_t  cur_kind;

    logic [1:0]            ch_q;
    logic [NWIN-1:0]       win_hit;
    logic [NWIN-1:0]       reg_sel_q;
    logic [`ISP_SA_W-1:0]  reg_addr_q;
    logic                  reg_wr_q;
    logic                  reg_rd_q;
    logic [7:0]            reg_wdata_q;
    logic [7:0]            sd_out_q;
    logic                  hi_mode_q;
    logic                  strap_done_q;
    logic [2:0]            req_q;
    logic [1:0]            cnt_q [3];
    logic [8:0]            dma_map_q;
    logic [23:0]           irq_map_q;
    logic                  map_loaded_q;
    logic [`ISP_NIRQ-1:0]  irq_q;
    logic [`ISP_NIRQ-1:0]  irq_oe_q;
    logic                  rdy_now;
    logic [7:0]            rd_byte;

    isp_fifo_if #(.WIDTH(8)) play_if ();

    isp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .mclk  (mclk),
        .rst_n (rst_n),
        .fi    (play_if.fifo)
    );

    for (genvar w = 0; w < NWIN; w++) begin : g_win
        assign win_hit[w] = cfg_win_en[w] &
            win_match(sa, cfg_win_base[w*12 +: 12], cfg_win_mask[w*12 +: 12]);
    end

    // upper bits must be zero only when the pins carry address
    wire addr_ok   = !hi_mode_q || (ext_addr_hi == `ISP_HI_ZERO);
    wire strobe_on = !ior_n || !iow_n;
    wire [2:0] ack_act = ~{dma_ack_third_n, dma_ack_second_n, dma_ack_first_n};
    wire [2:0] ack_on  = ack_act & cfg_chan_en;
    wire [1:0] ack_ch  = ack_on[0] ? 2'd0 : (ack_on[1] ? 2'd1 : 2'd2);
    // aen separates decoded io from dma cycles
    wire io_hit  = !aen && addr_ok && (|win_hit);
    wire dma_hit = aen && (|ack_on);
    wire start   = (st_q == isp_pkg::ISP_IDLE) && strobe_on;
    wire active  = start || (st_q == isp_pkg::ISP_WAIT);
    wire [1:0] cur_ch  = start ? ack_ch : ch_q;
    wire       cap_sel = (cur_ch == 2'd2);

    // classify the cycle at the strobe edge
    assign new_kind = (io_hit && !ior_n) ? isp_pkg::ISP_K_IORD :
                      (io_hit && !iow_n) ? isp_pkg::ISP_K_IOWR :
                      (dma_hit && !iow_n && ack_ch == 2'd0) ? isp_pkg::ISP_K_DMWR :
                      (dma_hit && !ior_n && ack_ch != 2'd0) ? isp_pkg::ISP_K_DMRD :
                      isp_pkg::ISP_K_NONE;
    assign cur_kind = start ? new_kind : kind_q;

    always_comb begin
        case (cur_kind)
            isp_pkg::ISP_K_IORD: rdy_now = (st_q == isp_pkg::ISP_WAIT) && reg_rvalid;
            isp_pkg::ISP_K_DMWR: rdy_now = play_if.in_ready;
            isp_pkg::ISP_K_DMRD: rdy_now = cap_valid[cap_sel];
            default:             rdy_now = 1'b1;
        endcase
    end

    wire fire     = active && rdy_now;
    wire dma_acc  = fire && (cur_kind == isp_pkg::ISP_K_DMWR ||
                             cur_kind == isp_pkg::ISP_K_DMRD);
    assign rd_byte = (cur_kind == isp_pkg::ISP_K_IORD) ? reg_rdata
                                                       : cap_data[cap_sel*8 +: 8];

    always_comb begin
        st_d = st_q;
        case (st_q)
            isp_pkg::ISP_IDLE: begin
                if (start) begin
                    st_d = fire ? isp_pkg::ISP_HOLD : isp_pkg::ISP_WAIT;
                end
            end
            // a strobe dropped mid-wait abandons the cycle
            isp_pkg::ISP_WAIT: begin
                if (!strobe_on) begin
                    st_d = isp_pkg::ISP_IDLE;
                end else if (fire) begin
                    st_d = isp_pkg::ISP_HOLD;
                end
            end
            isp_pkg::ISP_HOLD: begin
                if (!strobe_on) begin
                    st_d = isp_pkg::ISP_IDLE;
                end
            end
            default: st_d = isp_pkg::ISP_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= isp_pkg::ISP_IDLE;
            kind_q <= isp_pkg::ISP_K_NONE;
            ch_q   <= 2'd0;
        end else begin
            st_q   <= st_d;
            kind_q <= cur_kind;
            ch_q   <= cur_ch;
        end
    end

    // register side strobes and latched decode
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_sel_q   <= '0;
            reg_addr_q  <= '0;
            reg_wr_q    <= 1'b0;
            reg_rd_q    <= 1'b0;
            reg_wdata_q <= 8'h00;
        end else begin
            if (start) begin
                reg_sel_q  <= first_one(win_hit);
                reg_addr_q <= sa;
            end
            reg_wr_q <= fire && cur_kind == isp_pkg::ISP_K_IOWR;
            reg_rd_q <= start && new_kind == isp_pkg::ISP_K_IORD;
            if (fire && cur_kind == isp_pkg::ISP_K_IOWR) begin
                reg_wdata_q <= sd_in;
            end
        end
    end

    // read byte held until the strobe ends
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sd_out_q <= 8'h00;
        end else if (fire && (cur_kind == isp_pkg::ISP_K_IORD ||
                              cur_kind == isp_pkg::ISP_K_DMRD)) begin
            sd_out_q <= rd_byte;
        end
    end

    // dma write bytes enter the playback fifo
    assign play_if.in_valid  = fire && cur_kind == isp_pkg::ISP_K_DMWR;
    assign play_if.in_data   = sd_in;
    assign play_if.out_ready = play_ready;
    assign play_data         = play_if.out_data;
    assign play_valid        = play_if.out_valid;
    assign cap_ready[0] = fire && cur_kind == isp_pkg::ISP_K_DMRD && !cap_sel;
    assign cap_ready[1] = fire && cur_kind == isp_pkg::ISP_K_DMRD && cap_sel;

    // request held until the whole transfer unit has moved
    for (genvar c = 0; c < 3; c++) begin : g_ch
        wire src_ok  = (c == 0) ? play_if.in_ready : cap_valid[(c == 0) ? 0 : c-1];
        wire ch_acc  = dma_acc && cur_ch == 2'(c);
        wire last    = cnt_q[c] == cfg_xfer_bytes;
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                req_q[c] <= 1'b0;
                cnt_q[c] <= 2'd0;
            end else if (!cfg_chan_en[c]) begin
                req_q[c] <= 1'b0;
                cnt_q[c] <= 2'd0;
            end else if (ch_acc) begin
                req_q[c] <= !last;
                cnt_q[c] <= last ? 2'd0 : cnt_q[c] + 2'd1;
            end else if (!req_q[c] && !ack_act[c] && src_ok) begin
                req_q[c] <= 1'b1;
            end
        end
    end

    // strap caught on the first edge after reset release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_mode_q    <= `ISP_STRAP_ADDR;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            hi_mode_q    <= peripheral_read_strobe_in == `ISP_STRAP_ADDR;
            strap_done_q <= 1'b1;
        end
    end

    // channel and line assignment, remapped by resource data
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dma_map_q    <= `ISP_DMA_MAP_RST;
            irq_map_q    <= `ISP_IRQ_MAP_RST;
            map_loaded_q <= 1'b0;
        end else if (res_load) begin
            dma_map_q    <= res_dma_map;
            irq_map_q    <= res_irq_map;
            map_loaded_q <= 1'b1;
        end
    end

    // outputs float unless enabled; value gated as well
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q    <= '0;
            irq_oe_q <= '0;
        end else begin
            irq_q    <= irq_evt & cfg_irq_en;
            irq_oe_q <= cfg_irq_en;
        end
    end

    // bus driven only while our read strobe is low and data is latched
    assign sd_oe = st_q == isp_pkg::ISP_HOLD && !ior_n &&
                   (kind_q == isp_pkg::ISP_K_IORD || kind_q == isp_pkg::ISP_K_DMRD);
    assign sd_out = sd_out_q;
    // open drain: only ever pulls low while waiting
    assign iochrdy_oe  = st_q == isp_pkg::ISP_WAIT;
    assign iochrdy_out = 1'b0;
    assign dma_req_first  = req_q[0];
    assign dma_req_second = req_q[1];
    assign dma_req_third  = req_q[2];
    assign host_irq_out   = irq_q;
    assign host_irq_oe    = irq_oe_q;
    assign addr_hi_mode   = hi_mode_q;
    assign dma_chan_map   = dma_map_q;
    assign irq_line_map   = irq_map_q;
    assign reg_sel        = reg_sel_q;
    assign reg_addr       = reg_addr_q;
    assign reg_wr         = reg_wr_q;
    assign reg_rd         = reg_rd_q;
    assign reg_wdata      = reg_wdata_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_upper_alias_block : assert property (
        start && hi_mode_q && ext_addr_hi != 4'h0 && !aen |=> !reg_rd && !reg_wr)
        else $error("io decode accepted with upper address bits set");
    chk_dma_no_regs : assert property (
        start && aen |=> !reg_rd && !reg_wr)
        else $error("register strobe during dma cycle");
    chk_io_write_data : assert property (
        start && io_hit && ior_n && !iow_n |=> reg_wr && reg_wdata == $past(sd_in))
        else $error("io write not passed to register side");
    chk_io_read_stretch : assert property (
        start && io_hit && !ior_n |=> reg_rd && iochrdy_oe)
        else $error("io read did not stretch with channel ready");
    chk_read_return : assert property (
        st_q == isp_pkg::ISP_WAIT && kind_q == isp_pkg::ISP_K_IORD && reg_rvalid && !ior_n
        |=> !iochrdy_oe && sd_oe && sd_out == $past(reg_rdata))
        else $error("read data not returned after ready");
    chk_bus_release : assert property (
        sd_oe |-> !ior_n && !iochrdy_oe && !reg_wr)
        else $error("data bus driven outside a read");
    chk_req_full_unit : assert property (
        $fell(dma_req_first) && $past(cfg_chan_en[0]) |-> $past(dma_acc)
        && $past(cnt_q[0]) == $past(cfg_xfer_bytes))
        else $error("dma request dropped before unit complete");
    chk_dma_capture : assert property (
        start && aen && ack_on[0] && !iow_n && play_if.in_ready
        |-> play_if.in_valid ##1 st_q == isp_pkg::ISP_HOLD)
        else $error("dma write byte not captured");
    chk_map_default : assert property (
        !map_loaded_q |-> dma_chan_map == 9'h0c8 && irq_line_map == 24'hfc_b975)
        else $error("default channel or line map lost");
    chk_irq_gate : assert property (
        ##1 (host_irq_out & ~$past(cfg_irq_en)) == 6'h00 && host_irq_oe == $past(cfg_irq_en))
        else $error("interrupt asserted while not enabled");
    chk_strap_frozen : assert property (
        strap_done_q |=> $stable(addr_hi_mode))
        else $error("strap mode changed after capture");
    chk_win_onehot : assert property (
        reg_wr |-> $onehot(reg_sel))
        else $error("decode selected not exactly one function");

    cov_io_read_wait : cover property (
        start && new_kind == isp_pkg::ISP_K_IORD ##1 iochrdy_oe [*3] ##1 sd_oe);
    cov_dma_write : cover property (play_if.in_valid && play_if.in_ready);
    cov_dma_read : cover property (|cap_ready ##1 sd_oe);
    cov_fifo_full : cover property ($fell(dma_req_first) && !play_if.in_ready);
endmodule : isp_bus_port

//--- sim/isp_host_model.sv
// host side model: cpu io cycles and the system dma controller
`timescale 1ns/1ns
module isp_host_model (
    input  wire logic        mclk,
    output logic      [11:0] sa,
    output logic      [3:0]  ext_addr_hi,
    output logic             aen,
    output logic             ior_n,
    output logic             iow_n,
    output logic      [7:0]  sd_in,
    input  wire logic [7:0]  sd_out,
    input  wire logic        sd_oe,
    input  wire logic        iochrdy_out,
    input  wire logic        iochrdy_oe,
    output logic      [2:0]  ack_n
);
    logic [7:0] drv_q = 8'h00;
    logic       drv_en = 1'h0;
    logic [7:0] pat_q = 8'h00;
    // open-drain ready line with pull-up
    wire        chrdy = iochrdy_oe ? iochrdy_out : 1'h1;
    // a released bus shows a moving pattern so a stale byte cannot pass as read data
    assign sd_in = drv_en ? drv_q : (sd_oe ? sd_out : pat_q);

    always @(posedge mclk) pat_q <= pat_q + 8'h3b;

    initial begin
        {sa, ext_addr_hi, aen, ior_n, iow_n, ack_n} = {12'h000, 4'h0, 1'h0, 1'h1, 1'h1, 3'h7};
    end

    // one byte per strobe, aen marks dma
    task automatic xfer(input logic rd, input logic [11:0] a, input logic [3:0] hi,
                        input logic dm, input logic [2:0] ak, input logic [7:0] wd,
                        output logic [7:0] rdata, output logic stretched, output logic ok);
        int n;
        @(negedge mclk);
        {sa, ext_addr_hi, aen, ack_n, drv_q, drv_en} = {a, hi, dm, ak, wd, ~rd};
        {ior_n, iow_n} = {~rd, rd};
        n = 0;
        stretched = 1'h0;
        // hold the strobe while ready is low
        do begin
            @(negedge mclk);
            n++;
            if (!chrdy) stretched = 1'h1;
        end while (!chrdy && n < 64);
        ok = (n < 64);
        @(posedge mclk);
        rdata = sd_in;
        @(negedge mclk);
        {ior_n, iow_n, drv_en, ack_n, aen} = {1'h1, 1'h1, 1'h0, 3'h7, 1'h0};
        @(negedge mclk);
    endtask : xfer
endmodule : isp_host_model

//--- sim/test_isp_bus_port.sv
// self-checking bench for the isa slave bus port
`timescale 1ns/1ns
`include "isp_defines.svh"
module test_isp_bus_port;
    logic        mclk, rst_n = 1'h0, strap = 1'h1, res_load = 1'h0, play_ready = 1'h0;
    logic        reg_rvalid = 1'h0;
    logic [7:0]  reg_rdata = 8'h00;
    logic [8:0]  res_dma = 9'h000;
    logic [23:0] res_irq = 24'h00_0000;
    logic [5:0]  irq_en = 6'h00, irq_evt = 6'h00;
    logic [15:0] cap_data = 16'h0000;
    logic [1:0]  cap_valid = 2'h0, rd_pipe = 2'h0;
    wire  [11:0] sa, reg_addr;
    wire  [3:0]  hi, reg_sel;
    wire  [2:0]  ack_n;
    wire  [7:0]  sd_in, sd_out, reg_wdata, play_data;
    wire  [5:0]  irq_o, irq_oe;
    wire  [8:0]  dma_map;
    wire  [23:0] irq_map;
    wire         aen, ior_n, iow_n, sd_oe, chrdy_o, chrdy_oe, req1, req2, req3, hi_mode;
    wire         reg_wr, reg_rd, play_valid;
    wire  [1:0]  cap_rdy;
    int          num_errors = 0, cmp_count = 0, wr_cnt = 0, req_falls = 0, cap_pops = 0, n;
    logic [7:0]  wr_last, rdat;
    logic [3:0]  sel_last;
    logic        req_prev = 1'h0, strch, ok;

    isp_host_model host (
        .mclk(mclk), .sa(sa), .ext_addr_hi(hi), .aen(aen), .ior_n(ior_n), .iow_n(iow_n),
        .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe), .iochrdy_out(chrdy_o),
        .iochrdy_oe(chrdy_oe), .ack_n(ack_n)
    );
    isp_bus_port dut (
        .mclk(mclk), .rst_n(rst_n), .sa(sa), .ext_addr_hi(hi), .aen(aen), .ior_n(ior_n),
        .iow_n(iow_n), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe), .iochrdy_out(chrdy_o),
        .iochrdy_oe(chrdy_oe), .dma_ack_first_n(ack_n[0]), .dma_ack_second_n(ack_n[1]),
        .dma_ack_third_n(ack_n[2]), .dma_req_first(req1), .dma_req_second(req2),
        .dma_req_third(req3), .host_irq_out(irq_o), .host_irq_oe(irq_oe),
        .peripheral_read_strobe_in(strap), .addr_hi_mode(hi_mode), .cfg_win_en(4'h3),
        .cfg_win_base(48'h0000_0022_0534), .cfg_win_mask(48'h0000_0000_0003),
        .cfg_chan_en(3'h7), .cfg_xfer_bytes(2'h1), .cfg_irq_en(irq_en), .res_load(res_load),
        .res_dma_map(res_dma), .res_irq_map(res_irq), .dma_chan_map(dma_map),
        .irq_line_map(irq_map), .reg_sel(reg_sel), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .play_data(play_data), .play_valid(play_valid),
        .play_ready(play_ready), .cap_data(cap_data), .cap_valid(cap_valid), .cap_ready(cap_rdy),
        .irq_evt(irq_evt)
    );

    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        req_prev <= req1;
        if (req_prev && !req1) req_falls++;
        if (|cap_rdy) cap_pops++;
        if (reg_wr) begin
            wr_cnt++;
            wr_last <= reg_wdata;
            sel_last <= reg_sel;
        end
    end

    // slow register file: answers two cycles late so the read must stretch
    always @(negedge mclk) begin
        rd_pipe <= {rd_pipe[0], reg_rd};
        reg_rvalid <= rd_pipe[1];
        reg_rdata <= reg_addr[7:0] ^ 8'ha5;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic do_reset(input logic s);
        strap = s;
        rst_n = 1'h0;
        repeat (3) @(negedge mclk);
        rst_n = 1'h1;
        repeat (2) @(negedge mclk);
    endtask : do_reset

    task automatic io(input logic rd, input logic [11:0] a, input logic [3:0] h,
                      input logic dm, input logic [2:0] ak, input logic [7:0] wd);
        host.xfer(rd, a, h, dm, ak, wd, rdat, strch, ok);
        if (!ok) begin
            num_errors++;
            conclude();
        end
    endtask : io

    task automatic t_maps();
        check(dma_map, `ISP_DMA_MAP_RST, "dma map default");
        check(irq_map, `ISP_IRQ_MAP_RST, "irq map default");
        check(hi_mode, `ISP_STRAP_ADDR, "strap high");
        {res_dma, res_irq, res_load} = {9'h1d1, 24'h12_3456, 1'h1};
        @(negedge mclk);
        res_load = 1'h0;
        @(negedge mclk);
        check(dma_map, 9'h1d1, "dma map loaded");
        check(irq_map, 24'h12_3456, "irq map loaded");
        do_reset(1'h0);
        check(hi_mode, 1'h0, "strap low");
        check(dma_map, `ISP_DMA_MAP_RST, "dma map back");
        n = wr_cnt;
        io(1'h0, 12'h534, 4'h2, 1'h0, 3'h7, 8'h11);
        check(wr_cnt, n + 1, "upper pins not address");
        do_reset(1'h1);
    endtask : t_maps

    task automatic t_io();
        n = wr_cnt;
        io(1'h0, 12'h535, 4'h0, 1'h0, 3'h7, 8'h96);
        check(wr_cnt, n + 1, "write taken");
        check(wr_last, 8'h96, "write data");
        check(sel_last, 4'h1, "window zero");
        io(1'h0, 12'h220, 4'h0, 1'h0, 3'h7, 8'h5e);
        check(sel_last, 4'h2, "window one");
        io(1'h0, 12'h535, 4'h8, 1'h0, 3'h7, 8'h01);
        io(1'h0, 12'h535, 4'h0, 1'h1, 3'h7, 8'h02);
        io(1'h0, 12'h538, 4'h0, 1'h0, 3'h7, 8'h03);
        check(wr_cnt, n + 2, "refused writes");
        io(1'h1, 12'h536, 4'h0, 1'h0, 3'h7, 8'h00);
        check(rdat, 8'h36 ^ 8'ha5, "read data");
        check(strch, 1'h1, "read stretched");
        check(sd_oe, 1'h0, "bus released");
    endtask : t_io

    task automatic t_dma();
        n = req_falls;
        check(req1, 1'h1, "request up");
        io(1'h0, 12'h000, 4'h0, 1'h1, 3'h6, 8'h3c);
        check(req_falls, n, "request held mid unit");
        io(1'h0, 12'h000, 4'h0, 1'h1, 3'h6, 8'hc3);
        check(req_falls, n + 1, "request ends with unit");
        for (int i = 0; i < 14; i++) io(1'h0, 12'h000, 4'h0, 1'h1, 3'h6, 8'h40 + 8'(i));
        check(req1, 1'h0, "no request when full");
        play_ready = 1'h1;
        for (int i = 0; i < 16; i++) begin
            check(play_data, (i == 0) ? 8'h3c : (i == 1) ? 8'hc3 : 8'h3e + i, "order");
            @(negedge mclk);
        end
        play_ready = 1'h0;
        check(play_valid, 1'h0, "fifo drained");
        {cap_data, cap_valid} = {16'h7ea7, 2'h3};
        @(negedge mclk);
        check(req2, 1'h1, "capture request");
        check(req3, 1'h1, "third request");
        io(1'h1, 12'h000, 4'h0, 1'h1, 3'h5, 8'h00);
        check(rdat, 8'ha7, "second channel byte");
        io(1'h1, 12'h000, 4'h0, 1'h1, 3'h3, 8'h00);
        check(rdat, 8'h7e, "third channel byte");
        check(cap_pops, 2, "capture pops");
        check(sd_oe, 1'h0, "bus released after dma");
    endtask : t_dma

    task automatic t_irq();
        {irq_en, irq_evt} = {6'h29, 6'h3f};
        repeat (2) @(negedge mclk);
        check(irq_oe, 6'h29, "irq enables");
        check(irq_o, 6'h29, "gated irq");
        irq_evt = 6'h00;
        repeat (2) @(negedge mclk);
        check(irq_o, 6'h00, "irq cleared");
    endtask : t_irq

    initial begin
        do_reset(1'h1);
        t_maps();
        t_io();
        t_dma();
        t_irq();
        conclude();
    end
endmodule : test_isp_bus_port
